// [logic/pcsm_reg_bank.sv]
// Management register bank of a gigabit PCS, served over a clause 22 frame.
// Assumes MDC and MDIO arrive from pins and are oversampled by sys_clk;
// the negotiation done pulse and link state come from logic on sys_clk.
//
// Notes on behaviour
// - Enabled interrupt sets status on negotiation done.
// - Status stays set until written zero.
// - Disabled interrupt forces status bit to zero.
// - Interrupt output mirrors the status bit.
// - Interrupt enable is read/write, resets to one.
// - Reserved bits read zero, writes ignored.
// - Unmapped addresses read zero, writes ignored.
// - Control 0, status 1, identifier 2-3, extended 15.
// - Power down clears only via reset bit.
// - Loopback bit selects internal loopback, resets zero.
// - Ten-bit build drives wrap output from loopback.
// - Ten-bit build ignores the power down bit.
// - Isolate bit read/write, resets to one.
// - Speed bits read fixed for 1000 Mbps.
// - Duplex bit always reads one.
// - Collision test bit always reads zero.
// - Negotiation control bits are plain storage.
// - Link status latches low, refreshed on read.
`timescale 1ns/100ps
module pcsm_reg_bank
   import pcsm_pkg::*;
#(
   parameter bit          TBI_BUILD   = 1'b0,    // Ten-bit interface build.
   parameter bit          HAS_AUTONEG = 1'b1,    // Interrupt register present.
   parameter logic [15:0] PHY_ID_HI   = 16'h0000, // Arbitrary identifier value.
   parameter logic [15:0] PHY_ID_LO   = 16'h0000  // Arbitrary identifier value.
) (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       mdc,
   input  wire logic       mdioIn,
   output logic            mdioOut,
   output logic            mdioOe,
   input  wire logic [4:0] phyAddr,
   input  wire logic       anDoneIn,
   input  wire logic       linkStatusIn,
   output logic            negotiation_done_irq_out,
   output logic            softResetOut,
   output logic            loopbackOut,
   output logic            wrapOut,
   output logic            powerDownOut,
   output logic            isolateOut
);
   // All state of the bank: frame engine and stored register bits.
   typedef struct packed {
      logic        mdcPrev;   // Last synchronised MDC level.
      pcsm_state_t fsm;       // Frame phase.
      logic [3:0]  bitCnt;    // Bit index within a phase.
      logic        isRead;    // Current frame is a read.
      logic        hit;       // Frame is addressed to us with a valid opcode.
      logic [4:0]  regAddr;   // Register addressed by the frame.
      logic [15:0] shift;     // Header, read data or write data.
      logic        mdioOut;   // Driven MDIO level.
      logic        mdioOe;    // High while we drive MDIO.
      logic        loopback;
      logic        anEnable;
      logic        powerDown;
      logic        isolate;
      logic        anRestart;
      logic        unidir;
      logic        softReset; // One-cycle pulse after a reset bit write.
      logic        intEnable;
      logic        intStatus;
      logic        linkLatch;
   } pcsm_regs_t;

   // Reset image of the state.
   localparam pcsm_regs_t Q_RESET = '{
      mdcPrev:   1'b1,
      fsm:       ST_IDLE,
      bitCnt:    4'h0,
      isRead:    1'b0,
      hit:       1'b0,
      regAddr:   5'h00,
      shift:     16'h0000,
      mdioOut:   1'b0,
      mdioOe:    1'b0,
      loopback:  RST_LOOP,
      anEnable:  RST_AN_EN,
      powerDown: RST_PWR,
      isolate:   RST_ISO,
      anRestart: RST_AN_RST,
      unidir:    RST_UNIDIR,
      softReset: 1'b0,
      intEnable: RST_INT_EN,
      intStatus: RST_INT_ST,
      linkLatch: 1'b0
   };

   pcsm_regs_t  q;         // Registered state.
   pcsm_regs_t  next_q;    // Next state.
   logic [1:0]  pinSync;   // Synchronised {mdc, mdio}.
   logic        mdcSync;   // Synchronised MDC.
   logic        mdioSync;  // Synchronised MDIO.
   logic        mdcRise;   // One-cycle pulse on an MDC rising edge.
   logic [15:0] shiftIn;   // Shift register with the sampled bit appended.
   logic        wrDone;    // Last data bit of a write to us sampled.
   logic [15:0] ctrlWord;  // Control register read value.
   logic [15:0] statWord;  // Status register read value.
   logic [15:0] intWord;   // Interrupt control register read value.
   logic [15:0] rdWord;    // Read value of the addressed register.
   logic        mapHit;    // Addressed register exists.

   // Both pins are asynchronous to sys_clk and pass two flip-flops first.
   pcsm_sync2 #(
      .W(2)
   ) u_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .asyncIn ({mdc, mdioIn}),
      .syncOut (pinSync)
   );

   assign mdcSync  = pinSync[1];
   assign mdioSync = pinSync[0];
   assign mdcRise  = mdcSync & ~q.mdcPrev;
   assign shiftIn  = {q.shift[14:0], mdioSync};

   // A write takes effect only once all sixteen data bits have arrived.
   assign wrDone = mdcRise && (q.fsm == ST_DATA) && (q.bitCnt == DATA_LAST)
                   && !q.isRead && q.hit;

   // Fixed bits come from constants; reserved bits stay zero.
   assign ctrlWord = CTL_FIXED
                   | (16'(q.loopback)  << CTL_LOOP)
                   | (16'(q.anEnable)  << CTL_AN_EN)
                   | (16'(q.powerDown) << CTL_PWR)
                   | (16'(q.isolate)   << CTL_ISO)
                   | (16'(q.anRestart) << CTL_AN_RST)
                   | (16'(q.unidir)    << CTL_UNIDIR);
   assign statWord = STAT_FIXED | (16'(q.linkLatch) << STAT_LINK);
   assign intWord  = (16'(q.intStatus) << INT_STATUS)
                   | (16'(q.intEnable) << INT_ENABLE);

   // Address decode; register 16 only exists in the negotiation build.
   assign mapHit = (q.regAddr == ADDR_CTRL) || (q.regAddr == ADDR_STAT)
                || (q.regAddr == ADDR_ID_HI) || (q.regAddr == ADDR_ID_LO)
                || (q.regAddr == ADDR_EXT)
                || (HAS_AUTONEG && (q.regAddr == ADDR_INT));

   // Read mux; anything outside the map reads as zero.
   assign rdWord = !mapHit                    ? 16'h0000
                 : (q.regAddr == ADDR_CTRL)  ? ctrlWord
                 : (q.regAddr == ADDR_STAT)  ? statWord
                 : (q.regAddr == ADDR_ID_HI) ? PHY_ID_HI
                 : (q.regAddr == ADDR_ID_LO) ? PHY_ID_LO
                 : (q.regAddr == ADDR_EXT)   ? EXT_FIXED
                 : intWord;

   // Next state: frame engine on MDC edges, then register updates.
   always_comb begin
      next_q           = q;
      next_q.mdcPrev   = mdcSync;
      next_q.softReset = 1'b0;
      if (mdcRise) begin
         unique case (q.fsm)
            // Preamble ones are skipped; the first zero is the start bit.
            ST_IDLE: begin
               if (!mdioSync) begin
                  next_q.fsm = ST_START;
               end
            end
            // The second start bit must be one, else the frame is dropped.
            ST_START: begin
               next_q.bitCnt = 4'h0;
               next_q.fsm    = mdioSync ? ST_HDR : ST_IDLE;
            end
            // Opcode, PHY address and register address, MSB first.
            ST_HDR: begin
               next_q.shift  = shiftIn;
               next_q.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == HDR_LAST) begin
                  next_q.fsm     = ST_TA;
                  next_q.bitCnt  = 4'h0;
                  next_q.regAddr = shiftIn[4:0];
                  next_q.isRead  = (shiftIn[11:10] == OP_READ);
                  next_q.hit     = (shiftIn[9:5] == phyAddr)
                                && ((shiftIn[11:10] == OP_READ)
                                 || (shiftIn[11:10] == OP_WRITE));
               end
            end
            // Turnaround: on a read we drive zero for the second bit.
            ST_TA: begin
               next_q.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == 4'h0) begin
                  if (q.isRead && q.hit) begin
                     next_q.mdioOe  = 1'b1;
                     next_q.mdioOut = 1'b0;
                     next_q.shift   = rdWord;
                     // Reading status refreshes the latched link bit.
                     if (q.regAddr == ADDR_STAT) begin
                        next_q.linkLatch = linkStatusIn;
                     end
                  end
               end else begin
                  next_q.fsm    = ST_DATA;
                  next_q.bitCnt = 4'h0;
                  if (q.mdioOe) begin
                     next_q.mdioOut = q.shift[15];
                     next_q.shift   = {q.shift[14:0], 1'b0};
                  end
               end
            end
            // Data: shift out on reads, shift in on writes.
            ST_DATA: begin
               next_q.bitCnt = q.bitCnt + 4'h1;
               if (q.mdioOe) begin
                  next_q.mdioOut = q.shift[15];
                  next_q.shift   = {q.shift[14:0], 1'b0};
               end else begin
                  next_q.shift = shiftIn;
               end
               // The last bit is sampled now; release the line.
               if (q.bitCnt == DATA_LAST) begin
                  next_q.fsm     = ST_IDLE;
                  next_q.mdioOe  = 1'b0;
                  next_q.mdioOut = 1'b0;
               end
            end
            // Unused codes fall back to idle.
            default: begin
               next_q.fsm    = ST_IDLE;
               next_q.mdioOe = 1'b0;
            end
         endcase
      end

      // Control register write; reserved and fixed bits are ignored.
      if (wrDone && (q.regAddr == ADDR_CTRL)) begin
         if (shiftIn[CTL_RESET]) begin
            // Reset restores every control bit, power down included.
            next_q.loopback  = RST_LOOP;
            next_q.anEnable  = RST_AN_EN;
            next_q.powerDown = RST_PWR;
            next_q.isolate   = RST_ISO;
            next_q.anRestart = RST_AN_RST;
            next_q.unidir    = RST_UNIDIR;
            next_q.softReset = 1'b1;
         end else begin
            next_q.loopback  = shiftIn[CTL_LOOP];
            next_q.anEnable  = shiftIn[CTL_AN_EN];
            next_q.anRestart = shiftIn[CTL_AN_RST];
            next_q.unidir    = shiftIn[CTL_UNIDIR];
            next_q.isolate   = shiftIn[CTL_ISO];
            // Writing zero cannot leave power down; only reset can.
            next_q.powerDown = q.powerDown | shiftIn[CTL_PWR];
         end
      end

      // Interrupt enable write, only where the register exists.
      if (wrDone && HAS_AUTONEG && (q.regAddr == ADDR_INT)) begin
         next_q.intEnable = shiftIn[INT_ENABLE];
         // Writing zero clears status; writing one leaves it alone.
         if (!shiftIn[INT_STATUS]) begin
            next_q.intStatus = 1'b0;
         end
      end

      // A completion in the clearing cycle still sets the bit.
      if (HAS_AUTONEG && anDoneIn) begin
         next_q.intStatus = 1'b1;
      end
      if (!next_q.intEnable) begin
         next_q.intStatus = 1'b0;
      end

      // Any link loss pulls the latched bit low until it is read.
      if (!linkStatusIn) begin
         next_q.linkLatch = 1'b0;
      end
   end

   // State register with asynchronous reset to the reset image.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= Q_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Outputs come straight from state, gated by the build option.
   assign mdioOut                  = q.mdioOut;
   assign mdioOe                   = q.mdioOe;
   assign negotiation_done_irq_out = q.intStatus;
   assign softResetOut             = q.softReset;
   assign loopbackOut              = q.loopback & ~TBI_BUILD;
   assign wrapOut                  = q.loopback & TBI_BUILD;
   assign powerDownOut             = q.powerDown & ~TBI_BUILD;
   assign isolateOut               = q.isolate;

   // Checks on the bank, all in the sys_clk domain.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   AST_IRQ_SET: assert property (
      (HAS_AUTONEG && anDoneIn && q.intEnable
       && !(wrDone && (q.regAddr == ADDR_INT) && !shiftIn[INT_ENABLE]))
      |=> negotiation_done_irq_out)
      else $error("Interrupt not set on negotiation done.");

   AST_IRQ_HOLD: assert property (
      $fell(negotiation_done_irq_out)
      |-> $past(wrDone && (q.regAddr == ADDR_INT)))
      else $error("Interrupt status cleared without a write.");

   AST_IRQ_OFF: assert property (
      !q.intEnable |-> !negotiation_done_irq_out)
      else $error("Interrupt status set while disabled.");

   AST_EN_WRITE: assert property (
      (wrDone && HAS_AUTONEG && (q.regAddr == ADDR_INT))
      |=> (q.intEnable == $past(shiftIn[INT_ENABLE])))
      else $error("Interrupt enable did not take written value.");

   AST_RSVD_ZERO: assert property (
      ((q.regAddr == ADDR_CTRL) |-> (rdWord[4:0] == 5'h00))
      and ((q.regAddr == ADDR_INT) |-> (rdWord[15:2] == 14'h0000)))
      else $error("Reserved bits read nonzero.");

   AST_UNMAPPED: assert property (
      !mapHit |-> (rdWord == 16'h0000))
      else $error("Unmapped address read nonzero.");

   AST_PWR_HOLD: assert property (
      $fell(q.powerDown) |-> q.softReset)
      else $error("Power down left without reset bit.");

   AST_TBI_GATE: assert property (
      TBI_BUILD |-> (!powerDownOut && !loopbackOut && (wrapOut == q.loopback)))
      else $error("Ten-bit build outputs wrong.");

   AST_FIXED_BITS: assert property (
      (q.regAddr == ADDR_CTRL) |-> (rdWord[CTL_SPD_MSB] && !rdWord[CTL_SPD_LSB]
                                    && rdWord[CTL_DUPLEX] && !rdWord[CTL_COLTEST]))
      else $error("Fixed control bits wrong.");

   AST_LINK_LOW: assert property (
      !linkStatusIn |=> !q.linkLatch)
      else $error("Link loss not latched.");

   AST_TA_ZERO: assert property (
      $rose(mdioOe) |-> (!mdioOut && (q.fsm == ST_TA) && q.isRead && q.hit))
      else $error("Turnaround drive wrong.");
endmodule : pcsm_reg_bank

// [logic/pcsm_pkg.sv]
// Constants and types shared by the PCS management register bank.
// Assumes a clause 22 management frame sampled on the 25 MHz system clock.
package pcsm_pkg;
   // Management register addresses.
   localparam logic [4:0] ADDR_CTRL  = 5'h00;
   localparam logic [4:0] ADDR_STAT  = 5'h01;
   localparam logic [4:0] ADDR_ID_HI = 5'h02;
   localparam logic [4:0] ADDR_ID_LO = 5'h03;
   localparam logic [4:0] ADDR_EXT   = 5'h0F;
   localparam logic [4:0] ADDR_INT   = 5'h10;

   // Control register field positions.
   localparam int CTL_RESET   = 15;
   localparam int CTL_LOOP    = 14;
   localparam int CTL_SPD_LSB = 13;
   localparam int CTL_AN_EN   = 12;
   localparam int CTL_PWR     = 11;
   localparam int CTL_ISO     = 10;
   localparam int CTL_AN_RST  = 9;
   localparam int CTL_DUPLEX  = 8;
   localparam int CTL_COLTEST = 7;
   localparam int CTL_SPD_MSB = 6;
   localparam int CTL_UNIDIR  = 5;

   // Interrupt control and status register field positions.
   localparam int INT_STATUS = 1;
   localparam int INT_ENABLE = 0;
   localparam int STAT_LINK  = 2;

   // Reset values of the stored control bits.
   localparam logic RST_LOOP   = 1'b0;
   localparam logic RST_AN_EN  = 1'b1;
   localparam logic RST_PWR    = 1'b0;
   localparam logic RST_ISO    = 1'b1;
   localparam logic RST_AN_RST = 1'b0;
   localparam logic RST_UNIDIR = 1'b0;
   localparam logic RST_INT_EN = 1'b1;
   localparam logic RST_INT_ST = 1'b0;

   // Constant bits: full duplex and 1000 Mbps in control, abilities in status.
   localparam logic [15:0] CTL_FIXED  = 16'h0140;
   localparam logic [15:0] STAT_FIXED = 16'h01E0;
   localparam logic [15:0] EXT_FIXED  = 16'h8000;

   // Frame fields: opcodes and last bit counts of each phase.
   localparam logic [1:0] OP_READ   = 2'b10;
   localparam logic [1:0] OP_WRITE  = 2'b01;
   localparam logic [3:0] HDR_LAST  = 4'hB;
   localparam logic [3:0] DATA_LAST = 4'hF;

   // Frame states, Gray coded along idle, start, header, turnaround, data.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_HDR   = 3'b011,
      ST_TA    = 3'b010,
      ST_DATA  = 3'b110
   } pcsm_state_t;
endpackage : pcsm_pkg

// [logic/pcsm_sync2.sv]
// Two flip-flop synchroniser for pin inputs of the management port.
// Assumes the inputs are asynchronous to sys_clk; only stage two is read.
`timescale 1ns/100ps
module pcsm_sync2 #(
   parameter int W = 2
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   // Both stages of the synchroniser.
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } pcsm_sync_t;

   pcsm_sync_t q;
   pcsm_sync_t next_q;

   // Stage one is read only by stage two, to contain metastability.
   always_comb begin
      next_q        = q;
      next_q.stage1 = asyncIn;
      next_q.stage2 = q.stage1;
   end

   // MDIO idles high through the pull-up, so both stages reset to ones.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '1;
      end else begin
         q <= next_q;
      end
   end

   assign syncOut = q.stage2;
endmodule : pcsm_sync2

// [bench/pcsm_sme_model.sv]
// Station management model that runs clause 22 frames on the MDIO pins.
// Assumes the bench resolves the shared wire with a pull-up and feeds it back.
`timescale 1ns/100ps
module pcsm_sme_model
   import pcsm_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic mdioWire,
   output logic      mdc,
   output logic      smeOut,
   output logic      smeOe
);
   // The clock stands low between frames and the line is released.
   initial begin
      mdc    = 1'b0;
      smeOut = 1'b1;
      smeOe  = 1'b0;
   end

   // One frame with suppressed preamble: start, op, addresses, turnaround, data.
   // Each bit is four system clocks low and four high, so 320 ns per bit.
   // A read releases the line before the turnaround so the device can answer.
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regA,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] bits;
      bits = {2'b01, op, phy, regA, 2'b10, wd};
      for (int i = 31; i >= 0; i--) begin
         @(negedge sys_clk);
         mdc    = 1'b0;
         smeOe  = (op != OP_READ) || (i > 17);
         smeOut = bits[i];
         repeat (3) @(negedge sys_clk);
         if (i < 16) begin
            rd[i] = mdioWire;
         end
         @(negedge sys_clk);
         mdc = 1'b1;
         repeat (3) @(negedge sys_clk);
      end
      @(negedge sys_clk);
      mdc   = 1'b0;
      smeOe = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : xfer
endmodule : pcsm_sme_model

// [bench/tb_top.sv]
// Self-checking bench for the PCS management register bank.
// Two banks share one MDIO wire: the main build and a ten-bit build.
`timescale 1ns/100ps
module tb_top;
   import pcsm_pkg::*;
   localparam logic [4:0] PHY_MAIN = 5'h01; // Address of the main build.
   localparam logic [4:0] PHY_TBI  = 5'h02; // Address of the ten-bit build.
   localparam logic [4:0] PHY_NONE = 5'h03; // Address that nobody answers.
   logic sys_clk, resetn, mdc, mdioWire, smeOut, smeOe, anDoneIn, linkStatusIn;
   logic mainOut, mainOe, irq, softReset, loopMain, wrapMain, pwrMain, isoMain;
   logic tbiOut, tbiOe, loopTbi, wrapTbi, pwrTbi, sawReset;
   logic [15:0] ignored; // Read data of frames whose answer is not checked.
   int   nErrors, checks;

   // Open-drain style wire with a pull-up; a released line reads one.
   assign mdioWire = mainOe ? mainOut : (tbiOe ? tbiOut : (smeOe ? smeOut : 1'b1));

   pcsm_reg_bank #(.TBI_BUILD(1'b0), .HAS_AUTONEG(1'b1)) u_pcsm_reg_bank (
      .sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdioIn(mdioWire),
      .mdioOut(mainOut), .mdioOe(mainOe), .phyAddr(PHY_MAIN), .anDoneIn(anDoneIn),
      .linkStatusIn(linkStatusIn), .negotiation_done_irq_out(irq),
      .softResetOut(softReset), .loopbackOut(loopMain), .wrapOut(wrapMain),
      .powerDownOut(pwrMain), .isolateOut(isoMain));

   // The ten-bit build also stands for the build without the interrupt register.
   pcsm_reg_bank #(.TBI_BUILD(1'b1), .HAS_AUTONEG(1'b0)) u_pcsm_reg_bank_tbi (
      .sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdioIn(mdioWire),
      .mdioOut(tbiOut), .mdioOe(tbiOe), .phyAddr(PHY_TBI), .anDoneIn(anDoneIn),
      .linkStatusIn(linkStatusIn), .negotiation_done_irq_out(),
      .softResetOut(), .loopbackOut(loopTbi), .wrapOut(wrapTbi),
      .powerDownOut(pwrTbi), .isolateOut());

   pcsm_sme_model u_pcsm_sme_model (
      .sys_clk(sys_clk), .mdioWire(mdioWire), .mdc(mdc), .smeOut(smeOut), .smeOe(smeOe));

   // The reset pulse lasts one cycle, so a sticky flag records it.
   always @(posedge sys_clk) begin
      if (softReset === 1'b1) begin
         sawReset <= 1'b1;
      end
   end

   // Compares with case equality so an unknown never passes.
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [4:0] phy, input logic [4:0] a, input logic [15:0] d);
      logic [15:0] unused;
      u_pcsm_sme_model.xfer(OP_WRITE, phy, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [4:0] phy, input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] got;
      u_pcsm_sme_model.xfer(OP_READ, phy, a, 16'h0000, got);
      check($sformatf("phy %0h reg %0h", phy, a), got, exp);
   endtask : rd_chk

   // One-cycle completion pulse, then time for the status flop to settle.
   task automatic an_done;
      @(negedge sys_clk);
      anDoneIn = 1'b1;
      @(negedge sys_clk);
      anDoneIn = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : an_done

   task automatic give_verdict;
      if (nErrors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Thirty-five frames of 261 cycles each fit well inside this span.
   initial begin
      repeat (40000) @(posedge sys_clk);
      nErrors++;
      give_verdict();
   end

   initial begin
      resetn = 1'b0;
      anDoneIn = 1'b0;
      linkStatusIn = 1'b0;
      sawReset = 1'b0;
      nErrors = 0;
      checks = 0;
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      // Reset values and the decoded map.
      check("isolate", {15'h0, isoMain}, 16'h0001);
      rd_chk(PHY_MAIN, ADDR_CTRL, 16'h1540);
      rd_chk(PHY_MAIN, ADDR_INT, 16'h0001);
      rd_chk(PHY_MAIN, ADDR_STAT, 16'h01E0);
      rd_chk(PHY_MAIN, ADDR_ID_HI, 16'h0000);
      rd_chk(PHY_MAIN, ADDR_ID_LO, 16'h0000);
      rd_chk(PHY_MAIN, ADDR_EXT, 16'h8000);
      rd_chk(PHY_MAIN, 5'h04, 16'h0000);
      wr(PHY_MAIN, 5'h1F, 16'hFFFF);
      rd_chk(PHY_MAIN, 5'h1F, 16'h0000);
      // Without the interrupt register its address is unmapped and reads zero.
      rd_chk(PHY_TBI, ADDR_INT, 16'h0000);
      // Control bits: fixed bits ignore writes, power down sticks.
      wr(PHY_MAIN, ADDR_CTRL, 16'h7EFF);
      rd_chk(PHY_MAIN, ADDR_CTRL, 16'h5F60);
      check("loopback", {15'h0, loopMain}, 16'h0001);
      check("power down", {15'h0, pwrMain}, 16'h0001);
      wr(PHY_MAIN, ADDR_CTRL, 16'h0000);
      rd_chk(PHY_MAIN, ADDR_CTRL, 16'h0940);
      check("loopback off", {15'h0, loopMain}, 16'h0000);
      check("isolate off", {15'h0, isoMain}, 16'h0000);
      check("power held", {15'h0, pwrMain}, 16'h0001);
      wr(PHY_MAIN, ADDR_CTRL, 16'h8000);
      check("soft reset", {15'h0, sawReset}, 16'h0001);
      check("power cleared", {15'h0, pwrMain}, 16'h0000);
      rd_chk(PHY_MAIN, ADDR_CTRL, 16'h1540);
      // Ten-bit build: wrap follows loopback, power down has no effect.
      wr(PHY_TBI, ADDR_CTRL, 16'h4800);
      check("wrap", {13'h0, wrapTbi, loopTbi, pwrTbi}, 16'h0004);
      check("main untouched", {14'h0, wrapMain, loopMain}, 16'h0000);
      rd_chk(PHY_TBI, ADDR_CTRL, 16'h4940);
      // Interrupt: set, sticky, cleared by zero, forced off when disabled.
      an_done();
      check("irq set", {15'h0, irq}, 16'h0001);
      wr(PHY_MAIN, ADDR_INT, 16'h0003);
      rd_chk(PHY_MAIN, ADDR_INT, 16'h0003);
      wr(PHY_MAIN, ADDR_INT, 16'hFFFD);
      rd_chk(PHY_MAIN, ADDR_INT, 16'h0001);
      check("irq clear", {15'h0, irq}, 16'h0000);
      wr(PHY_MAIN, ADDR_INT, 16'h0000);
      an_done();
      rd_chk(PHY_MAIN, ADDR_INT, 16'h0000);
      wr(PHY_MAIN, ADDR_INT, 16'h0001);
      an_done();
      check("irq again", {15'h0, irq}, 16'h0001);
      wr(PHY_MAIN, ADDR_INT, 16'h0002);
      rd_chk(PHY_MAIN, ADDR_INT, 16'h0000);
      check("irq forced", {15'h0, irq}, 16'h0000);
      // Link latch: old value on the read that refreshes it, low after a drop.
      linkStatusIn = 1'b1;
      rd_chk(PHY_MAIN, ADDR_STAT, 16'h01E0);
      rd_chk(PHY_MAIN, ADDR_STAT, 16'h01E4);
      @(negedge sys_clk);
      linkStatusIn = 1'b0;
      @(negedge sys_clk);
      linkStatusIn = 1'b1;
      rd_chk(PHY_MAIN, ADDR_STAT, 16'h01E0);
      rd_chk(PHY_MAIN, ADDR_STAT, 16'h01E4);
      // Refused frames: bad opcode and foreign address leave state alone.
      u_pcsm_sme_model.xfer(2'b11, PHY_MAIN, ADDR_CTRL, 16'h4000, ignored);
      wr(PHY_NONE, ADDR_CTRL, 16'h4000);
      rd_chk(PHY_MAIN, ADDR_CTRL, 16'h1540);
      rd_chk(PHY_NONE, ADDR_CTRL, 16'hFFFF);
      give_verdict();
   end
endmodule : tb_top
